// ### imdu_defines.svh
`ifndef IMDU_DEFINES_SVH
`define IMDU_DEFINES_SVH
`define IMDU_MUL_LATENCY 5
`define IMDU_DIV_LAT_UNSIGNED_32 36
`define IMDU_DIV_SIGNED_EXTRA 2
`define IMDU_DIV_BITS 32
`define IMDU_SKIP_8 23
`define IMDU_SKIP_16 15
`define IMDU_SKIP_24 7
`define IMDU_RESULT_RESET 32'h0000_0000
`endif

// ### imdu_issuer.sv
`timescale 1ns/1ps
// ********************************************************************
// Issuing side of the integer pipeline.
// ********************************************************************
module imdu_issuer (
  input wire logic clk, // core clock
  input wire logic stall, // divide busy
  output imdu_pkg::imdu_req_t req // request to the unit
);
  initial begin
    req = '0;
  end

  // Holds the request until an edge sees the divider free.
  task automatic issue(input imdu_pkg::imdu_req_t r);
    req <= r;
    do begin
      @(posedge clk);
    end while (stall);
  endtask

  // Released operands flip so that a stale value is never reused.
  task automatic idle();
    req <= '{op: imdu_pkg::IMDU_OP_NONE,
      dividend_operand: ~req.dividend_operand,
      multiplier_operand: ~req.multiplier_operand, tag: ~req.tag};
  endtask
endmodule

// ### imdu_mul_stage.sv
`timescale 1ns/1ps
// One register stage of the multiplier pipe.
module imdu_mul_stage (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input imdu_pkg::imdu_stage_t d, // stage input
  output imdu_pkg::imdu_stage_t q // stage output
);
  imdu_pkg::imdu_stage_t q_reg;
  imdu_pkg::imdu_stage_t q_next;
  always_comb begin
    q_next = d;
    if (!resetn) begin
      q_next = '0;
    end
  end
  always_ff @(posedge clk) begin
    q_reg <= q_next;
  end
  assign q = q_reg;
endmodule

// ### imdu_pkg.sv
package imdu_pkg;
  typedef enum logic [3:0] {
    IMDU_OP_NONE = 4'h0,
    IMDU_OP_WIDE_S = 4'h1, // wide_product_signed_op
    IMDU_OP_WIDE_U = 4'h2, // wide_product_unsigned_op
    IMDU_OP_ACC_ADD_S = 4'h3, // accumulate_add_signed_op
    IMDU_OP_ACC_ADD_U = 4'h4, // accumulate_add_unsigned_op
    IMDU_OP_ACC_SUB_S = 4'h5, // accumulate_subtract_signed_op
    IMDU_OP_ACC_SUB_U = 4'h6, // accumulate_subtract_unsigned_op
    IMDU_OP_QUOT_S = 4'h7,
    IMDU_OP_QUOT_U = 4'h8, // quotient_unsigned_op
    IMDU_OP_GPR_MUL = 4'h9,
    IMDU_OP_MOVE_UPPER = 4'ha, // move_upper_result_op
    IMDU_OP_MOVE_BOTTOM = 4'hb // move_bottom_result_op
  } imdu_op_t;
  typedef struct packed {
    imdu_op_t op;
    logic [31:0] dividend_operand;
    logic [31:0] multiplier_operand;
    logic [4:0] tag;
  } imdu_req_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
    logic [4:0] tag;
  } imdu_rsp_t;
  typedef struct packed {
    logic valid;
    logic [2:0] kind;
    logic [4:0] tag;
    logic [63:0] prod;
  } imdu_stage_t;
  typedef enum logic [2:0] {
    IMDU_DIV_IDLE = 3'b001,
    IMDU_DIV_PREP = 3'b010,
    IMDU_DIV_RUN = 3'b100
  } imdu_div_state_t;
endpackage

// ### imdu_unit.sv
`timescale 1ns/1ps
`include "imdu_defines.svh"
module imdu_unit #(
  parameter int MUL_LAT = `IMDU_MUL_LATENCY
) (
  input wire logic clk, // core clock
  input wire logic resetn, // synchronous reset, active low
  input imdu_pkg::imdu_req_t req, // operation request, taken when op != none and the divider is idle
  output logic stall, // divide busy, hold the request
  output imdu_pkg::imdu_rsp_t rsp, // result to register file
  output logic [31:0] upper_result_register, // upper result register
  output logic [31:0] bottom_result_register // bottom result register
);
  localparam logic [2:0] K_NONE = 3'h0;
  localparam logic [2:0] K_WIDE = 3'h1;
  localparam logic [2:0] K_ADD = 3'h2;
  localparam logic [2:0] K_SUB = 3'h3;
  localparam logic [2:0] K_GPR = 3'h4;

  // ************************************************
  // Issue.
  // ************************************************
  imdu_pkg::imdu_op_t op;
  logic div_busy;
  logic take;
  logic is_signed;
  logic [2:0] kind;
  logic [63:0] prod;
  assign op = req.op;
  assign take = (op != imdu_pkg::IMDU_OP_NONE) && !div_busy;
  always_comb begin
    kind = K_NONE;
    is_signed = 1'b0;
    case (op)
      imdu_pkg::IMDU_OP_WIDE_S: begin
        kind = K_WIDE;
        is_signed = 1'b1;
      end
      imdu_pkg::IMDU_OP_WIDE_U: kind = K_WIDE;
      imdu_pkg::IMDU_OP_ACC_ADD_S: begin
        kind = K_ADD;
        is_signed = 1'b1;
      end
      imdu_pkg::IMDU_OP_ACC_ADD_U: kind = K_ADD;
      imdu_pkg::IMDU_OP_ACC_SUB_S: begin
        kind = K_SUB;
        is_signed = 1'b1;
      end
      imdu_pkg::IMDU_OP_ACC_SUB_U: kind = K_SUB;
      imdu_pkg::IMDU_OP_GPR_MUL: begin
        kind = K_GPR;
        is_signed = 1'b1;
      end
      default: kind = K_NONE;
    endcase
    if (!take) begin
      kind = K_NONE;
    end
  end
  always_comb begin
    if (is_signed) begin
      prod = $signed({{32{req.dividend_operand[31]}}, req.dividend_operand}) *
        $signed({{32{req.multiplier_operand[31]}}, req.multiplier_operand});
    end else begin
      prod = 64'(req.dividend_operand * 64'(req.multiplier_operand));
    end
  end

  // ************************************************
  // Multiplier pipe, one issue per clock.
  // ************************************************
  imdu_pkg::imdu_stage_t pipe [MUL_LAT-1:0];
  always_comb begin
    pipe[0].valid = (kind != K_NONE);
    pipe[0].kind = kind;
    pipe[0].tag = req.tag;
    pipe[0].prod = prod;
  end
  // Stages advance every clock regardless of the integer pipe.
  for (genvar i = 0; i < MUL_LAT - 1; i++) begin : g_pipe
    imdu_mul_stage u_stage (
      .clk(clk),
      .resetn(resetn),
      .d(pipe[i]),
      .q(pipe[i+1])
    );
  end
  imdu_pkg::imdu_stage_t tail;
  assign tail = pipe[MUL_LAT-1];

  // ************************************************
  // Divider.
  // ************************************************
  imdu_pkg::imdu_div_state_t dst_reg, dst_next;
  logic [31:0] rem_reg, rem_next, quo_reg, quo_next, dvs_reg, dvs_next;
  logic [5:0] cnt_reg, cnt_next;
  logic neg_q_reg, neg_q_next, neg_r_reg, neg_r_next;
  logic sgn_reg, sgn_next;
  logic div_done;
  logic [32:0] trial;
  logic [31:0] a_abs, b_abs;
  logic [5:0] skip;
  logic [5:0] shift;
  logic d_signed;
  assign d_signed = (op == imdu_pkg::IMDU_OP_QUOT_S);
  assign a_abs = (d_signed && req.dividend_operand[31]) ?
    32'(-req.dividend_operand) : req.dividend_operand;
  assign b_abs = (d_signed && req.multiplier_operand[31]) ?
    32'(-req.multiplier_operand) : req.multiplier_operand;
  // Early-in: width of the dividend decides the skipped iterations.
  always_comb begin
    if (req.dividend_operand[31:7] == {25{req.dividend_operand[7]}}) begin
      skip = 6'(`IMDU_SKIP_8);
    end else if (req.dividend_operand[31:15] ==
      {17{req.dividend_operand[15]}}) begin
      skip = 6'(`IMDU_SKIP_16);
    end else if (req.dividend_operand[31:23] ==
      {9{req.dividend_operand[23]}}) begin
      skip = 6'(`IMDU_SKIP_24);
    end else begin
      skip = 6'h00;
    end
    // An unsigned dividend with its top bit set is full width.
    if (!d_signed && req.dividend_operand[31]) begin
      skip = 6'h00;
    end
  end
  // A narrow dividend keeps at most its low 32-(skip+1) bits.
  assign shift = (skip == 6'h00) ? 6'h00 : skip + 6'h01;
  assign div_busy = (dst_reg != imdu_pkg::IMDU_DIV_IDLE);
  assign trial = {rem_reg, quo_reg[31]} - {1'b0, dvs_reg};
  always_comb begin
    dst_next = dst_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    dvs_next = dvs_reg;
    cnt_next = cnt_reg;
    neg_q_next = neg_q_reg;
    neg_r_next = neg_r_reg;
    sgn_next = sgn_reg;
    div_done = 1'b0;
    case (dst_reg)
      imdu_pkg::IMDU_DIV_IDLE: begin
        if (take && (op == imdu_pkg::IMDU_OP_QUOT_S ||
          op == imdu_pkg::IMDU_OP_QUOT_U)) begin
          rem_next = 32'h0000_0000;
          // Skipped high bits are sign copies and are shifted away now.
          quo_next = a_abs << shift;
          dvs_next = b_abs;
          cnt_next = 6'(`IMDU_DIV_BITS - 1) - shift;
          neg_q_next = d_signed && (req.dividend_operand[31] ^
            req.multiplier_operand[31]);
          neg_r_next = d_signed && req.dividend_operand[31];
          sgn_next = d_signed;
          dst_next = imdu_pkg::IMDU_DIV_RUN;
        end
      end
      imdu_pkg::IMDU_DIV_PREP: begin
        cnt_next = cnt_reg - 6'h01;
        if (cnt_reg == 6'h00) begin
          div_done = 1'b1;
          dst_next = imdu_pkg::IMDU_DIV_IDLE;
        end
      end
      imdu_pkg::IMDU_DIV_RUN: begin
        // One quotient bit per clock.
        cnt_next = cnt_reg - 6'h01;
        if (!trial[32]) begin
          rem_next = trial[31:0];
          quo_next = {quo_reg[30:0], 1'b1};
        end else begin
          rem_next = {rem_reg[30:0], quo_reg[31]};
          quo_next = {quo_reg[30:0], 1'b0};
        end
        if (cnt_reg == 6'h00) begin
          // Overhead cycles add a fixed 4 clocks (6 signed); only a full-width divide reaches the tabled latency.
          cnt_next = 6'(`IMDU_DIV_LAT_UNSIGNED_32 - `IMDU_DIV_BITS - 1)
            + (sgn_reg ? 6'(`IMDU_DIV_SIGNED_EXTRA) : 6'h00);
          dst_next = imdu_pkg::IMDU_DIV_PREP;
        end
      end
      default: dst_next = imdu_pkg::IMDU_DIV_IDLE;
    endcase
    if (!resetn) begin
      dst_next = imdu_pkg::IMDU_DIV_IDLE;
      cnt_next = 6'h00;
    end
  end
  // The loop runs once per kept dividend bit, then the padding countdown.
  always_ff @(posedge clk) begin
    dst_reg <= dst_next;
    rem_reg <= rem_next;
    quo_reg <= quo_next;
    dvs_reg <= dvs_next;
    cnt_reg <= cnt_next;
    neg_q_reg <= neg_q_next;
    neg_r_reg <= neg_r_next;
    sgn_reg <= sgn_next;
  end

  // ************************************************
  // Result registers and answer.
  // ************************************************
  logic [31:0] up_reg, up_next, bot_reg, bot_next;
  imdu_pkg::imdu_rsp_t rsp_reg, rsp_next;
  logic stall_reg, stall_next;
  logic [63:0] acc;
  logic [31:0] q_fix, r_fix;
  assign acc = {up_reg, bot_reg};
  assign q_fix = neg_q_next ? 32'(-quo_next) : quo_next;
  assign r_fix = neg_r_next ? 32'(-rem_next) : rem_next;
  always_comb begin
    up_next = up_reg;
    bot_next = bot_reg;
    rsp_next = '0;
    case (tail.kind)
      K_WIDE: {up_next, bot_next} = tail.prod;
      K_ADD: {up_next, bot_next} = acc + tail.prod;
      K_SUB: {up_next, bot_next} = acc - tail.prod;
      K_GPR: begin
        // Low word only; result registers left alone.
        rsp_next.valid = tail.valid;
        rsp_next.data = tail.prod[31:0];
        rsp_next.tag = tail.tag;
      end
      default: rsp_next = '0;
    endcase
    if (div_done) begin
      up_next = r_fix;
      bot_next = q_fix;
    end
    if (take && !rsp_next.valid && (op == imdu_pkg::IMDU_OP_MOVE_UPPER ||
      op == imdu_pkg::IMDU_OP_MOVE_BOTTOM)) begin
      rsp_next.valid = 1'b1;
      rsp_next.data = (op == imdu_pkg::IMDU_OP_MOVE_UPPER) ? up_reg : bot_reg;
      rsp_next.tag = req.tag;
    end
    stall_next = (dst_next != imdu_pkg::IMDU_DIV_IDLE);
    if (!resetn) begin
      up_next = `IMDU_RESULT_RESET;
      bot_next = `IMDU_RESULT_RESET;
      rsp_next = '0;
      stall_next = 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    up_reg <= up_next;
    bot_reg <= bot_next;
    rsp_reg <= rsp_next;
    stall_reg <= stall_next;
  end
  assign upper_result_register = up_reg;
  assign bottom_result_register = bot_reg;
  assign rsp = rsp_reg;
  // Stall mirrors the divider state; the combinational busy gates issue.
  assign stall = stall_reg;

  // ************************************************
  // Checks.
  // ************************************************
  sequence s_gpr_issue;
    take && op == imdu_pkg::IMDU_OP_GPR_MUL;
  endsequence
  a_gpr_mul_latency: assert property (@(posedge clk) disable iff (!resetn)
    s_gpr_issue |-> ##5 rsp.valid)
    else $error("register multiply result not at 5 clocks");
  a_wide_latency: assert property (@(posedge clk) disable iff (!resetn)
    (take && op == imdu_pkg::IMDU_OP_WIDE_U) |-> ##5
    {upper_result_register, bottom_result_register} ==
    $past(req.dividend_operand, 5) * 64'($past(req.multiplier_operand, 5)))
    else $error("wide product wrong or late");
  a_gpr_keeps_result: assert property (@(posedge clk) disable iff (!resetn)
    (tail.kind == K_GPR && !div_done) |=> $stable(upper_result_register))
    else $error("register multiply touched result register");
  a_div_stall: assert property (@(posedge clk) disable iff (!resetn)
    (div_busy && (op == imdu_pkg::IMDU_OP_MOVE_UPPER ||
    op == imdu_pkg::IMDU_OP_MOVE_BOTTOM) && tail.kind != K_GPR) |=>
    !rsp.valid)
    else $error("issue accepted during divide");
  a_div_u32_time: assert property (@(posedge clk) disable iff (!resetn)
    (take && op == imdu_pkg::IMDU_OP_QUOT_U && skip == 6'h00) |->
    ##[1:40] div_done)
    else $error("divide did not finish in time");
  a_div_one_bit: assert property (@(posedge clk) disable iff (!resetn)
    (dst_reg == imdu_pkg::IMDU_DIV_RUN && cnt_reg != 6'h00) |=>
    cnt_reg == $past(cnt_reg) - 6'h01)
    else $error("divide step count wrong");
  a_acc_add: assert property (@(posedge clk) disable iff (!resetn)
    (tail.kind == K_ADD && !div_done) |=>
    {upper_result_register, bottom_result_register} ==
    $past(acc) + $past(tail.prod))
    else $error("accumulate add wrong");
  a_acc_sub: assert property (@(posedge clk) disable iff (!resetn)
    (tail.kind == K_SUB && !div_done) |=>
    {upper_result_register, bottom_result_register} ==
    $past(acc) - $past(tail.prod))
    else $error("accumulate subtract wrong");
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`include "imdu_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic stall;
  logic [31:0] upper_result_register;
  logic [31:0] bottom_result_register;
  imdu_pkg::imdu_req_t req;
  imdu_pkg::imdu_rsp_t rsp;
  logic [63:0] acc;
  logic [63:0] q[$];
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  imdu_unit imdu_unit_inst (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .stall(stall),
    .rsp(rsp),
    .upper_result_register(upper_result_register),
    .bottom_result_register(bottom_result_register)
  );
  imdu_issuer imdu_issuer_inst (.clk(clk), .stall(stall), .req(req));

  // ******************************************************************
  // Reference model and comparisons.
  // ******************************************************************
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_lat(string what, int exp, int got);
    n_tests++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic send(imdu_pkg::imdu_op_t op, logic [31:0] a,
    logic [31:0] b);
    imdu_pkg::imdu_req_t r;
    r.op = op;
    r.dividend_operand = a;
    r.multiplier_operand = b;
    r.tag = 5'($urandom);
    imdu_issuer_inst.issue(r);
  endtask

  // Odd codes among the wide and accumulate operations are signed.
  function automatic void apply(imdu_pkg::imdu_op_t op, logic [31:0] a,
    logic [31:0] b);
    logic [63:0] p;
    p = op[0] ? 64'(longint'($signed(a)) * longint'($signed(b)))
      : {32'h0, a} * {32'h0, b};
    case (op)
      imdu_pkg::IMDU_OP_ACC_ADD_S, imdu_pkg::IMDU_OP_ACC_ADD_U: acc = acc + p;
      imdu_pkg::IMDU_OP_ACC_SUB_S, imdu_pkg::IMDU_OP_ACC_SUB_U: acc = acc - p;
      default: acc = p;
    endcase
  endfunction

  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    results();
  end

  // ******************************************************************
  // Test sequence.
  // ******************************************************************
  initial begin
    imdu_pkg::imdu_op_t op;
    logic [31:0] a, b, qt, rm;
    int s, n, t;
    void'($urandom(33));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("reset", 64'h0, {upper_result_register, bottom_result_register});
    chk("idle", 64'h0, {62'h0, rsp.valid, stall});
    acc = 64'h0;
    repeat (3) begin
      for (int i = 0; i < 6; i++) begin
        op = imdu_pkg::imdu_op_t'(4'(1 + i));
        a = $urandom;
        b = $urandom;
        send(op, a, b);
        apply(op, a, b);
        q.push_back(acc);
      end
      imdu_issuer_inst.idle();
      #1;
      for (int j = 6 - `IMDU_MUL_LATENCY; j < 6; j++) begin
        if (j > 6 - `IMDU_MUL_LATENCY) begin
          @(posedge clk);
          #1;
        end
        chk("acc", q[j], {upper_result_register, bottom_result_register});
      end
      q.delete();
    end
    for (int k = 0; k < 2; k++) begin
      send(k ? imdu_pkg::IMDU_OP_MOVE_BOTTOM : imdu_pkg::IMDU_OP_MOVE_UPPER,
        $urandom, $urandom);
      imdu_issuer_inst.idle();
      #1;
      chk("move", {31'h0, 1'b1, k ? acc[31:0] : acc[63:32]},
        {31'h0, rsp.valid, rsp.data});
    end
    for (int i = 0; i < 3; i++) begin
      a = $urandom;
      b = $urandom;
      send(imdu_pkg::IMDU_OP_GPR_MUL, a, b);
      q.push_back({32'h0, a * b});
    end
    imdu_issuer_inst.idle();
    repeat (`IMDU_MUL_LATENCY - 3) @(posedge clk);
    for (int j = 0; j < 3; j++) begin
      if (j > 0) @(posedge clk);
      #1;
      chk("gpr", {31'h0, 1'b1, q[j][31:0]}, {31'h0, rsp.valid, rsp.data});
    end
    chk("keep", acc, {upper_result_register, bottom_result_register});
    for (int k = 0; k < 9; k++) begin
      s = 8 * (1 + k % 4);
      op = k < 4 || k == 8 ? imdu_pkg::IMDU_OP_QUOT_U : imdu_pkg::IMDU_OP_QUOT_S;
      a = 32'($urandom & ((64'h1 << s) - 64'h1));
      a[s - 1 -: 2] = 2'b01;
      if (op == imdu_pkg::IMDU_OP_QUOT_S && $urandom % 2 == 1) a = -a;
      b = 32'(1 + $urandom % 200);
      if (op == imdu_pkg::IMDU_OP_QUOT_U) begin
        qt = a / b;
        rm = a % b;
      end else begin
        qt = $signed(a) / $signed(b);
        rm = $signed(a) % $signed(b);
      end
      send(op, a, b);
      t = cyc;
      if (k == 8) begin
        send(imdu_pkg::IMDU_OP_MOVE_BOTTOM, a, b);
        chk_lat("hold", s + 5, cyc - t);
        imdu_issuer_inst.idle();
        #1;
        chk("held", {32'h0, qt}, {32'h0, rsp.data});
      end else begin
        imdu_issuer_inst.idle();
        n = 0;
        do begin
          @(posedge clk);
          #1;
          n++;
        end while (stall === 1'b1 && n < 100);
        chk_lat("div", s + 4 + (op == imdu_pkg::IMDU_OP_QUOT_S ? 2 : 0), n);
        chk("div", {rm, qt}, {upper_result_register, bottom_result_register});
      end
    end
    results();
  end
endmodule
